// ---- include/sep_pkg.sv ----
// Constants shared by the serial EEPROM slave port and its array.
// Assumes a 50 MHz system clock that samples the two-wire pins.
//
// Summary of operation
// RULE1 - Data line is only pulled low or released, never driven high.
// RULE2 - Input bits sampled on clock rise; output bits change after clock fall.
// RULE3 - Data changes only with clock low; changes with clock high are start/stop.
// RULE4 - Data falling with clock high is start; a new transaction begins there.
// RULE5 - Data rising with clock high is stop; after a read it returns to standby.
// RULE6 - Words are 8 bits; each received word is acknowledged low in ninth clock.
// RULE7 - Standby at power-up and after stop once internal programming is done.
// RULE8 - Controller recovers by clocking up to 9 times, then issuing a start.
// RULE9 - Write-guard pin high blocks modification of the whole array.
// RULE10 - Smallest option: 256 pages of 64 bytes, 14-bit word address.
// RULE11 - Middle option: 512 pages of 64 bytes, 15-bit word address.
// RULE12 - Largest option: 512 pages of 128 bytes, 16-bit word address.
// RULE13 - Page writes buffered up to 64 or 128 bytes; partial pages accepted.
// RULE14 - A closed write sequence programs the array in at most 5 ms.
// RULE15 - Three select pins let up to eight devices share one bus.
// RULE16 - Address word select bits must match pins to acknowledge; eighth bit high reads.
// RULE17 - Page writes increment only in-page bits, wrapping within the same page.
// RULE18 - While programming, device address words are not acknowledged.
// RULE19 - Read address advances per byte and wraps from last byte to first.
// RULE20 - Guarded writes are still acknowledged but start no programming.
package sep_pkg;

    // ------------------------------------------------------------
    // Array organisation (largest option by default)
    // ------------------------------------------------------------
    localparam int ADDR_W_DEF = 16;                 // 14 / 15 / 16
    localparam int PAGE_W_DEF = 7;                  // 6 / 6 / 7
    localparam int WORD_BITS  = 8;

    // ------------------------------------------------------------
    // Device address word
    // ------------------------------------------------------------
    localparam logic [3:0] DEV_CODE   = 4'hA;       // Fixed 1010 prefix
    localparam int         CODE_MSB   = 7;
    localparam int         CODE_LSB   = 4;
    localparam int         SEL_MSB    = 3;
    localparam int         SEL_LSB    = 1;
    localparam int         RW_BIT     = 0;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_NS     = 20;
    localparam int TWR_NS     = 5_000_000;          // 5 ms longest write cycle
    localparam int TWR_CYCLES = TWR_NS / CLK_NS;    // Longest time rounds down

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [3:0] BITCNT_RST = 4'h0;
    localparam logic [7:0] BYTE_RST   = 8'h00;

endpackage

// ---- include/sep_mem_if.sv ----
// Link between the serial front end and the nonvolatile array.
// Assumes both ends run on the same system clock.
interface sep_mem_if #(
    parameter int ADDR_W = 16,
    parameter int PAGE_W = 7
);
    logic                     buf_clr;
    logic                     buf_we;
    logic [PAGE_W-1:0]        buf_off;
    logic [7:0]               buf_data;
    logic                     prog_start;
    logic [ADDR_W-PAGE_W-1:0] prog_row;
    logic [ADDR_W-1:0]        rd_addr;
    logic [7:0]               rd_data;
    logic                     busy;

    modport ctl (output buf_clr, buf_we, buf_off, buf_data, prog_start, prog_row, rd_addr,
                 input rd_data, busy);
    modport arr (input buf_clr, buf_we, buf_off, buf_data, prog_start, prog_row, rd_addr,
                 output rd_data, busy);
endinterface

// ---- core/sep_array.sv ----
// Byte array with page buffer and self-timed programming sequencer.
// Assumes the front end fills the buffer only while not busy.
module sep_array
    import sep_pkg::*;
#(
    parameter int ADDR_W     = ADDR_W_DEF,
    parameter int PAGE_W     = PAGE_W_DEF,
    parameter int TWR_CYCLES = sep_pkg::TWR_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    sep_mem_if.arr   m
);
    localparam int PAGE_BYTES = 2 ** PAGE_W;
    localparam int CNT_W      = $clog2(TWR_CYCLES + 1);

    logic [7:0]            mem_arr [2 ** ADDR_W];
    logic [7:0]            page_buf [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] valid_reg;
    logic                  busy_reg;
    logic [CNT_W-1:0]      cnt_reg;
    logic                  copy_now;
    logic [PAGE_W-1:0]     copy_idx;

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    assign m.rd_data = mem_arr[m.rd_addr];
    assign m.busy    = busy_reg;

    // One buffered byte per cycle during the first cycles of programming
    assign copy_idx = cnt_reg[PAGE_W-1:0];
    assign copy_now = busy_reg && (cnt_reg < CNT_W'(PAGE_BYTES));

    // ------------------------------------------------------------
    // Page buffer
    // ------------------------------------------------------------
    // Buffer contents, no reset needed: valid bits qualify them
    always_ff @(posedge clk) begin
        if (m.buf_we) begin
            page_buf[m.buf_off] <= m.buf_data;  // RULE13
        end
    end

    // Valid mask lets partial pages leave untouched bytes alone
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            valid_reg <= '0;
        end else if (m.buf_clr || (busy_reg && cnt_reg == CNT_W'(TWR_CYCLES - 1))) begin
            valid_reg <= '0;
        end else if (m.buf_we) begin
            valid_reg[m.buf_off] <= 1'h1;       // RULE13
        end
    end

    // ------------------------------------------------------------
    // Programming sequencer
    // ------------------------------------------------------------
    // Fixed-length cycle; copy finishes long before the timer ends
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_reg <= 1'h0;
            cnt_reg  <= '0;
        end else if (!busy_reg) begin
            busy_reg <= m.prog_start;           // RULE14
            cnt_reg  <= '0;
        end else if (cnt_reg == CNT_W'(TWR_CYCLES - 1)) begin
            busy_reg <= 1'h0;                   // RULE14
        end else begin
            cnt_reg <= cnt_reg + 1'h1;
        end
    end

    // Array write, one byte per cycle
    always_ff @(posedge clk) begin
        if (copy_now && valid_reg[copy_idx]) begin
            mem_arr[{m.prog_row, copy_idx}] <= page_buf[copy_idx];
        end
    end

endmodule

// ---- core/sep_slave.sv ----
// Two-wire serial slave front end of a byte-organised EEPROM.
// Assumes all pins are asynchronous to SYS_CLK, which oversamples SCL.
module sep_slave
    import sep_pkg::*;
#(
    parameter int ADDR_W     = ADDR_W_DEF,
    parameter int PAGE_W     = PAGE_W_DEF,
    parameter int TWR_CYCLES = sep_pkg::TWR_CYCLES
) (
    input  wire logic       SYS_CLK,
    input  wire logic       RESETN,
    input  wire logic       SCL_IN,
    input  wire logic       SDA_IN,
    output logic            SDA_OUT,
    output logic            SDA_OE_N,
    input  wire logic       WP_IN,
    input  wire logic [2:0] DEVICE_SELECT_PINS,
    output logic            STANDBY,
    output logic            BUSY
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_DEV, ST_AHI, ST_ALO, ST_WR, ST_RD, ST_WAIT
    } sep_state_t;

    sep_mem_if #(.ADDR_W(ADDR_W), .PAGE_W(PAGE_W)) mif ();

    logic [5:0]               meta_reg;
    logic [5:0]               sync_reg;
    logic                     scl_d_reg;
    logic                     sda_d_reg;
    logic                     scl_s;
    logic                     sda_s;
    logic                     wp_s;
    logic [2:0]               sel_s;
    logic                     scl_rise;
    logic                     scl_fall;
    logic                     start_det;
    logic                     stop_det;
    sep_state_t               state_reg;
    logic [3:0]               bit_cnt_reg;
    logic                     ack_ph_reg;
    logic [7:0]               shift_reg;
    logic [7:0]               tx_reg;
    logic [ADDR_W-1:0]        addr_reg;
    logic                     oe_n_reg;
    logic                     wr_seen_reg;
    logic                     buf_we_reg;
    logic                     buf_clr_reg;
    logic [PAGE_W-1:0]        buf_off_reg;
    logic [7:0]               buf_data_reg;
    logic                     prog_start_reg;
    logic [ADDR_W-PAGE_W-1:0] prog_row_reg;
    logic                     standby_reg;
    logic                     busy_out_reg;
    logic                     active;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    // Two flops on every pin; a third pair only for edge finding
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            meta_reg  <= 6'h3F;
            sync_reg  <= 6'h3F;
            scl_d_reg <= 1'h1;
            sda_d_reg <= 1'h1;
        end else begin
            meta_reg  <= {SCL_IN, SDA_IN, WP_IN, DEVICE_SELECT_PINS};
            sync_reg  <= meta_reg;
            scl_d_reg <= sync_reg[5];
            sda_d_reg <= sync_reg[4];
        end
    end

    assign scl_s = sync_reg[5];
    assign sda_s = sync_reg[4];
    assign wp_s  = sync_reg[3];
    assign sel_s = sync_reg[2:0];

    // Line events; data moving with the clock high is framing only
    assign scl_rise  = scl_s && !scl_d_reg;                         // RULE2
    assign scl_fall  = !scl_s && scl_d_reg;                         // RULE2
    assign start_det = scl_s && scl_d_reg && sda_d_reg && !sda_s;   // RULE3 RULE4
    assign stop_det  = scl_s && scl_d_reg && !sda_d_reg && sda_s;   // RULE3 RULE5
    assign active    = (state_reg != ST_IDLE) && (state_reg != ST_WAIT);

    // ------------------------------------------------------------
    // Protocol engine
    // ------------------------------------------------------------
    // Start and stop override any bit in progress
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            state_reg      <= ST_IDLE;              // RULE7
            bit_cnt_reg    <= BITCNT_RST;
            ack_ph_reg     <= 1'h0;
            shift_reg      <= BYTE_RST;
            tx_reg         <= BYTE_RST;
            addr_reg       <= '0;
            oe_n_reg       <= 1'h1;
            wr_seen_reg    <= 1'h0;
            buf_we_reg     <= 1'h0;
            buf_clr_reg    <= 1'h0;
            buf_off_reg    <= '0;
            buf_data_reg   <= BYTE_RST;
            prog_start_reg <= 1'h0;
            prog_row_reg   <= '0;
        end else begin
            buf_we_reg     <= 1'h0;
            buf_clr_reg    <= 1'h0;
            prog_start_reg <= 1'h0;
            if (start_det) begin
                state_reg   <= ST_DEV;              // RULE4
                bit_cnt_reg <= BITCNT_RST;
                ack_ph_reg  <= 1'h0;
                oe_n_reg    <= 1'h1;
            end else if (stop_det) begin
                // Guarded writes close silently without programming
                if (state_reg == ST_WR && wr_seen_reg && !wp_s && !mif.busy) begin
                    prog_start_reg <= 1'h1;         // RULE9 RULE14 RULE20
                end
                state_reg   <= ST_IDLE;             // RULE5 RULE7
                bit_cnt_reg <= BITCNT_RST;
                ack_ph_reg  <= 1'h0;
                oe_n_reg    <= 1'h1;
            end else if (active && scl_rise && !ack_ph_reg) begin
                if (bit_cnt_reg < 4'(WORD_BITS)) begin
                    if (state_reg != ST_RD) begin
                        shift_reg <= {shift_reg[6:0], sda_s};   // RULE2 RULE6
                    end
                    bit_cnt_reg <= bit_cnt_reg + 4'h1;
                end
            end else if (active && scl_rise && state_reg == ST_RD && sda_s) begin
                state_reg <= ST_WAIT;               // No ack from controller: stop sending
            end else if (active && scl_fall) begin
                if (ack_ph_reg) begin
                    ack_ph_reg  <= 1'h0;
                    bit_cnt_reg <= BITCNT_RST;
                    oe_n_reg    <= 1'h1;
                    if (state_reg == ST_RD) begin
                        tx_reg   <= {mif.rd_data[6:0], 1'h0};
                        oe_n_reg <= mif.rd_data[7];             // RULE1 RULE2
                        addr_reg <= addr_reg + 1'h1;            // RULE19
                    end
                end else if (bit_cnt_reg == 4'(WORD_BITS)) begin
                    ack_ph_reg <= 1'h1;
                    unique case (state_reg)
                        ST_DEV: begin
                            // Busy array stays silent so the controller can poll
                            if (shift_reg[CODE_MSB:CODE_LSB] == DEV_CODE &&
                                shift_reg[SEL_MSB:SEL_LSB] == sel_s && !mif.busy) begin // RULE15 RULE16 RULE18
                                oe_n_reg <= 1'h0;               // RULE6
                                if (shift_reg[RW_BIT]) begin
                                    state_reg <= ST_RD;         // RULE16
                                end else begin
                                    state_reg   <= ST_AHI;
                                    buf_clr_reg <= 1'h1;
                                    wr_seen_reg <= 1'h0;
                                end
                            end else begin
                                state_reg <= ST_WAIT;           // RULE16
                            end
                        end
                        ST_AHI: begin
                            addr_reg[ADDR_W-1:8] <= shift_reg[ADDR_W-9:0]; // RULE10 RULE11 RULE12
                            oe_n_reg  <= 1'h0;                  // RULE6
                            state_reg <= ST_ALO;
                        end
                        ST_ALO: begin
                            addr_reg[7:0] <= shift_reg;
                            oe_n_reg      <= 1'h0;              // RULE6
                            state_reg     <= ST_WR;
                        end
                        ST_WR: begin
                            buf_we_reg   <= 1'h1;               // RULE13
                            buf_off_reg  <= addr_reg[PAGE_W-1:0];
                            buf_data_reg <= shift_reg;
                            prog_row_reg <= addr_reg[ADDR_W-1:PAGE_W];
                            wr_seen_reg  <= 1'h1;
                            addr_reg     <= {addr_reg[ADDR_W-1:PAGE_W],
                                             addr_reg[PAGE_W-1:0] + 1'h1}; // RULE17
                            oe_n_reg     <= 1'h0;               // RULE6 RULE20
                        end
                        ST_RD: begin
                            oe_n_reg <= 1'h1;                   // Release for controller ack
                        end
                        default: begin
                            oe_n_reg <= 1'h1;
                        end
                    endcase
                end else if (state_reg == ST_RD) begin
                    oe_n_reg <= tx_reg[7];                      // RULE1 RULE2
                    tx_reg   <= {tx_reg[6:0], 1'h0};
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Array link
    // ------------------------------------------------------------
    assign mif.buf_clr    = buf_clr_reg;
    assign mif.buf_we     = buf_we_reg;
    assign mif.buf_off    = buf_off_reg;
    assign mif.buf_data   = buf_data_reg;
    assign mif.prog_start = prog_start_reg;
    assign mif.prog_row   = prog_row_reg;
    assign mif.rd_addr    = addr_reg;

    sep_array #(
        .ADDR_W     (ADDR_W),
        .PAGE_W     (PAGE_W),
        .TWR_CYCLES (TWR_CYCLES)
    ) u_array (
        .clk   (SYS_CLK),
        .rst_n (RESETN),
        .m     (mif.arr)
    );

    // ------------------------------------------------------------
    // Status outputs
    // ------------------------------------------------------------
    // Standby only once no transfer, no pending start and no programming remain
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            standby_reg  <= 1'h1;                   // RULE7
            busy_out_reg <= 1'h0;
        end else begin
            standby_reg  <= !active && !mif.busy && !prog_start_reg;   // RULE5 RULE7
            busy_out_reg <= mif.busy;
        end
    end

    // Pad is never driven high: the output value is a constant low
    assign SDA_OUT  = 1'h0;                         // RULE1
    assign SDA_OE_N = oe_n_reg;
    assign STANDBY  = standby_reg;
    assign BUSY     = busy_out_reg;

endmodule

// ---- tb/sep_ctl_model.sv ----
// Two-wire bus controller model: drives SCL and an open-drain SDA enable.
// Assumes the bench resolves SDA with a pull-up from every enable.
module sep_ctl_model (
    input  wire logic clk,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;

    // Bus idles high; the clock stands still between frames
    initial begin
        scl      = 1'b1;
        sda_oe_n = 1'b1;
    end

    // Everything moves on the falling system edge
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask

    // One bit, entered with SCL low: data moves mid-low, sampled late high
    task automatic bit_io(input logic b, output logic s);
        tick(2);
        sda_oe_n = b;
        tick(2);
        scl = 1'b1;
        tick(3);
        s = sda;
        tick(1);
        scl = 1'b0;
    endtask

    // Start, also as a repeated start from SCL low
    task automatic start();
        if (!scl) begin
            tick(2);
            sda_oe_n = 1'b1;
            tick(2);
            scl = 1'b1;
        end
        tick(2);
        sda_oe_n = 1'b0;
        tick(2);
        scl = 1'b0;
    endtask

    // Stop, entered with SCL low; extra wait lets the engine settle
    task automatic stop();
        tick(2);
        sda_oe_n = 1'b0;
        tick(2);
        scl = 1'b1;
        tick(4);
        sda_oe_n = 1'b1;
        tick(6);
    endtask

    // Byte out MSB first, then the answer bit
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(d[i], s);
        bit_io(1'b1, s);
        ack = !s;
    endtask

    // Byte in; more low means no acknowledge, which ends the read
    task automatic rbyte(input logic more, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, s);
            d[i] = s;
        end
        bit_io(!more, s);
    endtask

    // Clock until SDA reads high with SCL high, start right there, then stop
    task automatic recover();
        for (int i = 0; i < 9; i++) begin
            tick(4);
            scl = 1'b1;
            tick(3);
            if (sda) break;
            tick(1);
            scl = 1'b0;
        end
        sda_oe_n = 1'b0;
        tick(2);
        scl = 1'b0;
        stop();
    endtask
endmodule

// ---- tb/sep_slave_asserts.sv ----
// Concurrent checks on the pins of the serial EEPROM slave port.
// Assumes one SYS_CLK domain with RESETN as its asynchronous reset.
module sep_slave_asserts #(
    parameter int TWR_CYCLES = 300
) (
    input wire logic       SYS_CLK,
    input wire logic       RESETN,
    input wire logic       SCL_IN,
    input wire logic       SDA_IN,
    input wire logic       SDA_OUT,
    input wire logic       SDA_OE_N,
    input wire logic       WP_IN,
    input wire logic [2:0] DEVICE_SELECT_PINS,
    input wire logic       STANDBY,
    input wire logic       BUSY
);
    timeunit 1ns;
    timeprecision 1ps;

    int busy_cnt_reg;

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RESETN);

    // Length of the running programming cycle, in clocks
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) busy_cnt_reg <= 0;
        else if (BUSY) busy_cnt_reg <= busy_cnt_reg + 1;
        else busy_cnt_reg <= 0;
    end

    // Pin behaviour; the cycle length allows one clock either way for the flag lag
    a_pull_only: assert property (SDA_OUT == 1'b0) else $error("data pin driven high");
    a_moves_low: assert property ($changed(SDA_OE_N) |-> !SCL_IN) else $error("output moved, clock high");
    a_bit_holds: assert property ((!SDA_OE_N && $rose(SCL_IN)) |-> !SDA_OE_N [*4])
        else $error("low bit dropped in high phase");
    a_busy_deaf: assert property ($fell(SDA_OE_N) |-> !BUSY) else $error("answered while busy");
    a_guard_blocks: assert property ($rose(BUSY) |-> !WP_IN) else $error("guarded write programmed");
    a_cycle_len: assert property ($fell(BUSY) |-> busy_cnt_reg >= TWR_CYCLES - 1
        && busy_cnt_reg <= TWR_CYCLES + 1) else $error("write cycle length wrong");
    a_busy_awake: assert property (BUSY |-> !STANDBY) else $error("standby while programming");
    a_idle_quiet: assert property (STANDBY |-> SDA_OE_N) else $error("idle engine pulls data");
    a_start_wake: assert property ((SCL_IN && $fell(SDA_IN) && !BUSY) |-> ##[1:6] !STANDBY)
        else $error("start not taken");
    a_stop_sleep: assert property ((SCL_IN && $rose(SDA_IN) && !BUSY) |-> ##[1:8] (STANDBY || BUSY))
        else $error("stop did not end transfer");

    c_prog: cover property ($rose(BUSY));
    c_answer: cover property ($fell(SDA_OE_N));
    c_wake: cover property ($fell(STANDBY));
endmodule

bind sep_slave sep_slave_asserts #(.TWR_CYCLES(TWR_CYCLES)) u_chk (
    .SYS_CLK(SYS_CLK), .RESETN(RESETN), .SCL_IN(SCL_IN), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT),
    .SDA_OE_N(SDA_OE_N), .WP_IN(WP_IN), .DEVICE_SELECT_PINS(DEVICE_SELECT_PINS),
    .STANDBY(STANDBY), .BUSY(BUSY));

// ---- tb/tb.sv ----
// Self-checking bench for the serial EEPROM slave port.
// Assumes the controller model drives SCL and SDA, and SDA has a pull-up.
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int         AW  = 10;   // Small array keeps wrap tests short
    localparam int         PW  = 3;    // 8-byte pages
    localparam int         TWR = 300;
    localparam logic [2:0] SEL = 3'h5;

    typedef struct packed { logic [15:0] a; logic [7:0] d; } sep_row_t;

    logic       sys_clk, resetn, wp, scl, ctl_oe_n, sda_out, sda_oe_n, standby, busy;
    logic [7:0] exp_mem [0:1023];
    int         num_errors, checks_done;
    wire logic  sda = ctl_oe_n & sda_oe_n;  // Pulled up unless a party pulls low
    sep_row_t   rows [4] = '{'{16'h0000, 8'h3C}, '{16'h03FF, 8'hA5}, '{16'h0155, 8'h0F}, '{16'h02AA, 8'hF0}};

    // 50 MHz system clock
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    sep_slave #(.ADDR_W(AW), .PAGE_W(PW), .TWR_CYCLES(TWR)) dut (
        .SYS_CLK(sys_clk), .RESETN(resetn), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
        .SDA_OE_N(sda_oe_n), .WP_IN(wp), .DEVICE_SELECT_PINS(SEL), .STANDBY(standby), .BUSY(busy));
    sep_ctl_model ctl (.clk(sys_clk), .sda(sda), .scl(scl), .sda_oe_n(ctl_oe_n));

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic dev(input logic rw, input logic [2:0] s, output logic ack);
        ctl.start();
        ctl.wbyte({sep_pkg::DEV_CODE, s, rw}, ack);
    endtask

    // Device word and both address bytes, each answered
    task automatic set_addr(input logic [15:0] a);
        logic ack;
        dev(1'b0, SEL, ack);
        check("dev ack", 16'(ack), 16'h0001);
        ctl.wbyte(a[15:8], ack);
        check("addr hi ack", 16'(ack), 16'h0001);
        ctl.wbyte(a[7:0], ack);
        check("addr lo ack", 16'(ack), 16'h0001);
    endtask

    // Programming must start only when exp is set; polls during it go unanswered
    task automatic wait_prog(input logic exp);
        int   n;
        logic ack;
        n = 0;
        while (busy !== 1'b1 && n < 20) begin
            @(negedge sys_clk);
            n++;
        end
        check("prog start", 16'(busy), 16'(exp));
        if (busy === 1'b1) begin
            dev(1'b0, SEL, ack);
            ctl.stop();
            check("poll ack", 16'(ack), 16'h0000);
        end
        n = 0;
        while (busy !== 1'b0 && n < TWR + 20) begin
            @(negedge sys_clk);
            n++;
        end
        check("prog end", 16'(busy), 16'h0000);
    endtask

    // Page write; the expected image wraps inside the page
    task automatic write(input logic [15:0] a, input logic [7:0] d[$], input logic prog);
        logic ack;
        set_addr(a);
        foreach (d[i]) begin
            ctl.wbyte(d[i], ack);
            check("data ack", 16'(ack), 16'h0001);
            if (prog) exp_mem[{a[9:3], 3'(a[2:0] + 3'(i))}] = d[i];
        end
        ctl.stop();
        wait_prog(prog);
    endtask

    // Random read of n bytes, last one not acknowledged
    task automatic read(input logic [15:0] a, input int n, input string what);
        logic       ack;
        logic [7:0] d;
        set_addr(a);
        dev(1'b1, SEL, ack);
        check("read dev ack", 16'(ack), 16'h0001);
        for (int i = 0; i < n; i++) begin
            ctl.rbyte(i < n - 1, d);
            check(what, 16'(d), 16'(exp_mem[10'(a + 16'(i))]));
        end
        ctl.stop();
        check("standby after read", 16'(standby), 16'h0001);
    endtask

    // Watchdog: the whole sequence needs well under this
    initial begin
        repeat (60000) @(posedge sys_clk);
        num_errors++;
        stop_test();
    end

    initial begin
        logic [7:0] q[$];
        logic       ack;
        resetn = 1'b0;
        wp = 1'b0;
        num_errors = 0;
        checks_done = 0;
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        check("reset oe", 16'({sda_oe_n, standby, busy, sda_out}), 16'h000C);
        resetn = 1'b1;
        ctl.tick(4);
        // Ordinary cases: each row written, then read back
        foreach (rows[i]) begin
            q = {rows[i].d};
            write(rows[i].a, q, 1'b1);
            read(rows[i].a, 1, "row data");
        end
        // Ten bytes into an 8-byte page: last writes win
        q = {};
        for (int i = 0; i < 10; i++) q.push_back(8'h40 + 8'(i));
        write(16'h001E, q, 1'b1);
        read(16'h0018, 8, "page wrap");
        read(16'h03FF, 2, "array wrap");
        // Every select value; only our own is answered
        for (int s = 0; s < 8; s++) begin
            dev(1'b0, 3'(s), ack);
            ctl.stop();
            check("select ack", 16'(ack), 16'(3'(s) == SEL));
            check("select standby", 16'(standby), 16'h0001);
        end
        // Wrong fixed prefix with our own select bits is not answered
        ctl.start();
        ctl.wbyte({4'h5, SEL, 1'b0}, ack);
        ctl.stop();
        check("code ack", 16'(ack), 16'h0000);
        // Guarded write is answered but leaves the array alone
        wp = 1'b1;
        q = {8'h99, 8'h66};
        write(16'h0155, q, 1'b0);
        wp = 1'b0;
        read(16'h0155, 1, "guarded");
        // Abandoned read, then bus recovery
        set_addr(16'h0000);
        dev(1'b1, SEL, ack);
        check("abandon ack", 16'(ack), 16'h0001);
        ctl.recover();
        read(16'h0000, 1, "after recovery");
        // Reset in mid-transfer
        set_addr(16'h03FF);
        resetn = 1'b0;
        ctl.tick(2);
        check("mid reset", 16'({sda_oe_n, standby, busy}), 16'h0006);
        resetn = 1'b1;
        ctl.tick(4);
        read(16'h03FF, 1, "after reset");
        stop_test();
    end
endmodule
